// >>> esa_pkg.sv
// Purpose: Shared constants for the error signaling aggregator.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Channel numbers are fixed per source and never change at run time.
package esa_pkg;
	// ------------------------------------------------------------
	// Group sizes
	// ------------------------------------------------------------
	localparam int ESA_TOTAL_CH = 128;
	localparam int ESA_LOW_CH   = 64;
	localparam int ESA_MID_CH   = 32;
	localparam int ESA_HIGH_CH  = 32;
	// First low-severity channel fed from the generic input vector
	localparam int ESA_LOW_EXT_BASE = 18;
	// ------------------------------------------------------------
	// Fixed low-severity channel bindings
	// ------------------------------------------------------------
	localparam int ESA_CH_ADC2_PAR  = 1;
	localparam int ESA_CH_DMA_MPU   = 2;
	localparam int ESA_CH_DMA_PAR   = 3;
	localparam int ESA_CH_DMA_RD    = 5;
	localparam int ESA_CH_FLASH_COR = 6;
	localparam int ESA_CH_TCOP_PAR  = 7;
	localparam int ESA_CH_TXU_PAR   = 8;
	localparam int ESA_CH_TXU_MPU   = 9;
	localparam int ESA_CH_PLL_SLIP  = 10;
	localparam int ESA_CH_CLK_MON   = 11;
	localparam int ESA_CH_DMA_WR    = 13;
	localparam int ESA_CH_VTR_PAR   = 15;
	localparam int ESA_CH_SPI1_PAR  = 17;
	// Reserved channels 0, 4, 12, 14 and 16, held inactive
	localparam logic [63:0] ESA_LOW_RSV_MASK = 64'h0000_0000_0001_5011;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [63:0] ESA_LOW_RST  = 64'h0;
	localparam logic [31:0] ESA_GRP_RST  = 32'h0;
	localparam int ESA_MIN_LOW_TICKS     = 16;
	localparam int ESA_TB_DIV_W          = 8;
	// Fault pin sequencer states
	typedef enum logic [1:0] {ESA_IDLE, ESA_HOLD, ESA_WAIT} esa_state_t;
endpackage

// >>> esa_aggregator.sv
// Purpose: Gathers chip error channels in three severity groups and drives
//          interrupts and the active-low fault output pin.
// Assumes: All error inputs are synchronous pulses or levels on clk.
// Notes:   Configuration comes in on plain ports; there is no register bus.
`timescale 1ns/100ps
`default_nettype none
module esa_aggregator
	import esa_pkg::*;
#(
	parameter int MIN_LOW_TICKS = ESA_MIN_LOW_TICKS,
	parameter int TB_DIV_W      = ESA_TB_DIV_W
) (
	input  wire logic                clk,
	input  wire logic                rst,
	// Named low-severity sources
	input  wire logic                adc2_parity_err,
	input  wire logic                dma_mpu_err,
	input  wire logic                dma_parity_err,
	input  wire logic                dma_rd_err,
	input  wire logic                dma_wr_err,
	input  wire logic                flash_ctrl_corr_err,
	input  wire logic                flash_ctrl_eeprom_access,
	input  wire logic                timer_coprocessors_parity_err,
	input  wire logic                timer_transfer_units_parity_err,
	input  wire logic                timer_transfer_units_mpu_err,
	input  wire logic                pll_slip_err,
	input  wire logic                clk_mon_err,
	input  wire logic                vector_table_ram_parity_err,
	input  wire logic                first_buffered_serial_port_parity_err,
	input  wire logic [45:0]         low_err_ext,
	input  wire logic [31:0]         mid_err_in,
	input  wire logic [31:0]         high_err_in,
	// Configuration and clears
	input  wire logic [63:0]         low_int_en,
	input  wire logic [63:0]         low_int_high_pri,
	input  wire logic [63:0]         low_pin_en,
	input  wire logic [63:0]         low_clr,
	input  wire logic [31:0]         mid_clr,
	input  wire logic [31:0]         high_clr,
	input  wire logic [TB_DIV_W-1:0] timebase_div,
	input  wire logic                force_error,
	// Results
	output logic [63:0]              low_status,
	output logic [31:0]              mid_status,
	output logic [31:0]              high_status,
	output logic                     irq_low_pri,
	output logic                     irq_high_pri,
	output logic                     nmi_irq,
	output logic                     fault_out_n
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The three groups must add up to the full channel count
	if (ESA_LOW_CH + ESA_MID_CH + ESA_HIGH_CH != ESA_TOTAL_CH) begin : g_bad_ch
		$error("esa_aggregator: group sizes do not cover all channels");
	end
	if (MIN_LOW_TICKS < 1 || MIN_LOW_TICKS > 65535 || TB_DIV_W < 1 || TB_DIV_W > 16) begin : g_bad_par
		$error("esa_aggregator: timing parameters out of range");
	end

	// ------------------------------------------------------------
	// Channel binding
	// ------------------------------------------------------------
	// Hard wiring keeps the source to channel map out of software reach
	logic [63:0] low_raw;
	assign low_raw[0]                = 1'b0;
	assign low_raw[ESA_CH_ADC2_PAR]  = adc2_parity_err;
	assign low_raw[ESA_CH_DMA_MPU]   = dma_mpu_err;
	assign low_raw[ESA_CH_DMA_PAR]   = dma_parity_err;
	assign low_raw[4]                = 1'b0;
	assign low_raw[ESA_CH_DMA_RD]    = dma_rd_err;
	// EEPROM bank accesses report elsewhere, so they are kept off this channel
	assign low_raw[ESA_CH_FLASH_COR] = flash_ctrl_corr_err & ~flash_ctrl_eeprom_access;
	assign low_raw[ESA_CH_TCOP_PAR]  = timer_coprocessors_parity_err;
	assign low_raw[ESA_CH_TXU_PAR]   = timer_transfer_units_parity_err;
	assign low_raw[ESA_CH_TXU_MPU]   = timer_transfer_units_mpu_err;
	assign low_raw[ESA_CH_PLL_SLIP]  = pll_slip_err;
	assign low_raw[ESA_CH_CLK_MON]   = clk_mon_err;
	assign low_raw[12]               = 1'b0;
	assign low_raw[ESA_CH_DMA_WR]    = dma_wr_err;
	assign low_raw[14]               = 1'b0;
	assign low_raw[ESA_CH_VTR_PAR]   = vector_table_ram_parity_err;
	assign low_raw[16]               = 1'b0;
	assign low_raw[ESA_CH_SPI1_PAR]  = first_buffered_serial_port_parity_err;
	assign low_raw[63:ESA_LOW_EXT_BASE] = low_err_ext;

	// ------------------------------------------------------------
	// Sticky status per group
	// ------------------------------------------------------------
	// A new event beats a clear in the same cycle, so no error is lost
	wire logic [63:0] next_low_status  = ((low_status & ~low_clr) | low_raw) & ~ESA_LOW_RSV_MASK;
	wire logic [31:0] next_mid_status  = (mid_status & ~mid_clr) | mid_err_in;
	wire logic [31:0] next_high_status = (high_status & ~high_clr) | high_err_in;

	// Status registers
	always_ff @(posedge clk) begin
		if (rst) begin
			low_status  <= ESA_LOW_RST;
			mid_status  <= ESA_GRP_RST;
			high_status <= ESA_GRP_RST;
		end else begin
			low_status  <= next_low_status;
			mid_status  <= next_mid_status;
			high_status <= next_high_status;
		end
	end

	// ------------------------------------------------------------
	// Interrupt generation
	// ------------------------------------------------------------
	// Low group is masked and split by priority; high group never interrupts
	wire logic [63:0] low_active      = low_status & low_int_en;
	wire logic        next_irq_high   = |(low_active & low_int_high_pri);
	wire logic        next_irq_low    = |(low_active & ~low_int_high_pri);
	wire logic        next_nmi        = |mid_status;

	// Interrupt lines
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_low_pri  <= 1'b0;
			irq_high_pri <= 1'b0;
			nmi_irq      <= 1'b0;
		end else begin
			irq_low_pri  <= next_irq_low;
			irq_high_pri <= next_irq_high;
			nmi_irq      <= next_nmi;
		end
	end

	// ------------------------------------------------------------
	// Fault pin request
	// ------------------------------------------------------------
	// Low group only if enabled; mid and high always reach the pin
	// Severity ladder: low needs its enable, mid and high always count
	wire logic fault_req = (|(low_status & low_pin_en)) | (|mid_status) | (|high_status)
		| force_error;

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	// One tick every timebase_div+1 clocks sets the pin's hold time
	logic [TB_DIV_W-1:0] tb_cnt;
	wire logic           tb_tick     = (tb_cnt >= timebase_div);
	wire logic [TB_DIV_W-1:0] next_tb_cnt = tb_tick ? '0 : tb_cnt + 1'b1;

	// Prescaler
	always_ff @(posedge clk) begin
		if (rst) begin
			tb_cnt <= '0;
		end else begin
			tb_cnt <= next_tb_cnt;
		end
	end

	// ------------------------------------------------------------
	// Fault pin sequencer
	// ------------------------------------------------------------
	// A minimum low time lets a slow monitor see even a brief error
	localparam logic [15:0] HOLD_TICKS = 16'(MIN_LOW_TICKS);
	esa_state_t  state;
	esa_state_t  next_state;
	logic [15:0] low_cnt;
	logic [15:0] next_low_cnt;

	// Next state
	always_comb begin
		next_state   = state;
		next_low_cnt = low_cnt;
		case (state)
			ESA_IDLE: begin
				if (fault_req) begin
					next_state   = ESA_HOLD;
					next_low_cnt = HOLD_TICKS;
				end
			end
			ESA_HOLD: begin
				if (tb_tick) begin
					next_low_cnt = low_cnt - 16'h0001;
					if (low_cnt == 16'h0001) begin
						next_state = ESA_WAIT;
					end
				end
			end
			ESA_WAIT: begin
				// Pin releases only once every pin error is cleared
				if (!fault_req) begin
					next_state = ESA_IDLE;
				end
			end
			default: begin
				next_state = ESA_IDLE;
			end
		endcase
	end

	wire logic fault_active = (state != ESA_IDLE);

	// State and pin registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= ESA_IDLE;
			low_cnt     <= 16'h0000;
			fault_out_n <= 1'b1;
		end else begin
			state       <= next_state;
			low_cnt     <= next_low_cnt;
			fault_out_n <= ~fault_active;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Capture of a named low-group source
	property p_dma_mpu;
		@(posedge clk) disable iff (rst) dma_mpu_err |=> low_status[ESA_CH_DMA_MPU];
	endproperty
	a_dma_mpu: assert property (p_dma_mpu) else $error("dma protection fault not captured");

	// PLL slip capture
	property p_pll_slip;
		@(posedge clk) disable iff (rst) pll_slip_err |=> low_status[ESA_CH_PLL_SLIP];
	endproperty
	a_pll_slip: assert property (p_pll_slip) else $error("pll slip not captured");

	// EEPROM accesses stay off the flash channel
	property p_flash_excl;
		@(posedge clk) disable iff (rst)
			(flash_ctrl_eeprom_access && !low_status[ESA_CH_FLASH_COR]) |=> !low_status[ESA_CH_FLASH_COR];
	endproperty
	a_flash_excl: assert property (p_flash_excl) else $error("eeprom access reached flash channel");

	// Reserved channels never become active
	property p_reserved;
		@(posedge clk) disable iff (rst) (low_status & ESA_LOW_RSV_MASK) == 64'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved channel active");

	// Set beats clear on the low group
	property p_low_set;
		@(posedge clk) disable iff (rst)
			(low_raw != 64'h0) |=> ((low_status & $past(low_raw)) == $past(low_raw));
	endproperty
	a_low_set: assert property (p_low_set) else $error("low group event lost");

	// Masked low channels raise no interrupt
	property p_mask;
		@(posedge clk) disable iff (rst)
			((low_status & low_int_en) == 64'h0) |=> (!irq_low_pri && !irq_high_pri);
	endproperty
	a_mask: assert property (p_mask) else $error("masked channel raised interrupt");

	// Priority selection of an enabled low channel
	property p_prio;
		@(posedge clk) disable iff (rst)
			((low_status & low_int_en & low_int_high_pri) != 64'h0) |=> irq_high_pri;
	endproperty
	a_prio: assert property (p_prio) else $error("high priority interrupt missing");

	// Mid group always gives a non-maskable interrupt
	property p_mid_nmi;
		@(posedge clk) disable iff (rst) mid_err_in != 32'h0 |=> ##1 nmi_irq;
	endproperty
	a_mid_nmi: assert property (p_mid_nmi) else $error("mid group nmi missing");

	// High group alone gives no interrupt
	property p_high_quiet;
		@(posedge clk) disable iff (rst)
			(low_status == 64'h0 && mid_status == 32'h0) |=> (!nmi_irq && !irq_low_pri && !irq_high_pri);
	endproperty
	a_high_quiet: assert property (p_high_quiet) else $error("interrupt without low or mid cause");

	// Request reaches the pin in two cycles and stays low
	sequence s_enter_hold;
		!fault_active ##1 fault_active;
	endsequence
	sequence s_pin_low;
		!fault_out_n [*2];
	endsequence
	property p_pin;
		@(posedge clk) disable iff (rst) (fault_req && !fault_active) |-> s_enter_hold ##1 s_pin_low;
	endproperty
	a_pin: assert property (p_pin) else $error("fault pin not driven low");

	// Forcing drives the pin low
	property p_force;
		@(posedge clk) disable iff (rst) force_error |-> ##[1:2] !fault_out_n;
	endproperty
	a_force: assert property (p_force) else $error("forced fault not on pin");

	// Pin releases only after the hold count has run out
	property p_hold;
		@(posedge clk) disable iff (rst) $fell(fault_active) |-> ($past(low_cnt) == 16'h0000 && !$past(fault_req));
	endproperty
	a_hold: assert property (p_hold) else $error("fault pin released early");
endmodule
`default_nettype wire

// >>> esa_far_side.sv
// Purpose: External safety monitor that watches the active-low fault pin.
// Assumes: Same clock as the aggregator; synchronous active-high reset.
// Notes:   The error sources themselves are driven by the bench.
`timescale 1ns/100ps
`default_nettype none
module esa_far_side (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic fault_out_n,
	output logic      safe_state
);
	// --------------------------------------------------------
	// Safe state latch
	// --------------------------------------------------------
	// Latches on any low pin; only reset leaves it, since a pin that
	// recovers by itself is not trusted
	always_ff @(posedge clk) begin
		if (rst) begin
			safe_state <= 1'b0;
		end else if (!fault_out_n) begin
			safe_state <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> esa_tb.sv
// Purpose: Self-checking bench for the error signaling aggregator.
// Assumes: Inputs change at rising edges, outputs sampled at falling edges.
// Notes:   A short minimum hold keeps fault pin waits small.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		$display("wrong value %s exp %0h got %0h", nm, e, g); \
		fail_count++; \
	end \
end
module tb;
	import esa_pkg::*;
	localparam int MIN_T = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [12:0] ns = '0;
	logic        eeprom = 1'b0;
	logic [45:0] ext = '0;
	logic [31:0] mid_in = '0, high_in = '0, mid_clr = '0, high_clr = '0;
	logic [63:0] int_en = '0, hi_pri = '0, pin_en = '0, low_clr = '0;
	logic [7:0]  div = '0;
	logic        force_error = 1'b0;
	logic [63:0] low_status;
	logic [31:0] mid_status, high_status;
	logic        irq_low_pri, irq_high_pri, nmi_irq, fault_out_n, safe_state;
	int          fail_count = 0, total_checks = 0, cycles = 0;
	int          ch_tab [13] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 13, 15, 17};
	// --------------------------------------------------------
	// Design and monitor
	// --------------------------------------------------------
	esa_aggregator #(.MIN_LOW_TICKS(MIN_T)) u_esa_aggregator (
		.clk, .rst, .adc2_parity_err(ns[0]), .dma_mpu_err(ns[1]), .dma_parity_err(ns[2]), .dma_rd_err(ns[3]),
		.flash_ctrl_corr_err(ns[4]), .flash_ctrl_eeprom_access(eeprom), .timer_coprocessors_parity_err(ns[5]),
		.timer_transfer_units_parity_err(ns[6]), .timer_transfer_units_mpu_err(ns[7]), .pll_slip_err(ns[8]),
		.clk_mon_err(ns[9]), .dma_wr_err(ns[10]), .vector_table_ram_parity_err(ns[11]),
		.first_buffered_serial_port_parity_err(ns[12]), .low_err_ext(ext), .mid_err_in(mid_in),
		.high_err_in(high_in), .low_int_en(int_en), .low_int_high_pri(hi_pri), .low_pin_en(pin_en),
		.low_clr, .mid_clr, .high_clr, .timebase_div(div), .force_error, .low_status, .mid_status,
		.high_status, .irq_low_pri, .irq_high_pri, .nmi_irq, .fault_out_n);
	esa_far_side u_esa_far_side (.clk, .rst, .fault_out_n, .safe_state);
	// --------------------------------------------------------
	// Clock, timeout and helpers
	// --------------------------------------------------------
	always #2.5 clk = ~clk;
	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Clear every status bit with a one-cycle pulse
	task automatic clr_all();
		@(posedge clk);
		low_clr <= '1; mid_clr <= '1; high_clr <= '1;
		@(posedge clk);
		low_clr <= '0; mid_clr <= '0; high_clr <= '0;
		@(negedge clk);
	endtask
	// Bounded wait for a pin level, then compare
	task automatic wait_pin(input logic lvl, input int n, input string nm);
		for (int i = 0; i < n && fault_out_n !== lvl; i++) @(negedge clk);
		`CHK(nm, lvl, fault_out_n)
	endtask
	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic t_named();
		`CHK("reset pin", 1'b1, fault_out_n)
		`CHK("reset monitor", 1'b0, safe_state)
		for (int k = 0; k < 13; k++) begin
			@(posedge clk); ns[k] <= 1'b1;
			@(posedge clk); ns[k] <= 1'b0;
			@(negedge clk);
			`CHK("named status", 64'h1 << ch_tab[k], low_status)
			@(negedge clk);
			`CHK("masked irq", 2'b00, {irq_low_pri, irq_high_pri})
			`CHK("unrouted pin", 1'b1, fault_out_n)
			clr_all();
		end
		// Flash event during an emulated-EEPROM access is dropped
		@(posedge clk); ns[4] <= 1'b1; eeprom <= 1'b1;
		@(posedge clk); ns[4] <= 1'b0; eeprom <= 1'b0;
		@(negedge clk);
		`CHK("eeprom status", 64'h0, low_status)
		// Event and clear in one cycle: the event must survive
		@(posedge clk); ns[8] <= 1'b1; low_clr <= '1;
		@(posedge clk); ns[8] <= 1'b0; low_clr <= '0;
		@(negedge clk);
		`CHK("set beats clear", 64'h1 << 10, low_status)
		`CHK("monitor idle", 1'b0, safe_state)
		clr_all();
		$display("test named sources done");
	endtask
	task automatic t_all();
		@(posedge clk); ns <= '1; ext <= '1; mid_in <= '1; high_in <= '1;
		@(posedge clk); ns <= '0; ext <= '0; mid_in <= '0; high_in <= '0;
		@(negedge clk);
		`CHK("all low", ~64'h0000_0000_0001_5011, low_status)
		`CHK("all mid", 32'hffff_ffff, mid_status)
		`CHK("all high", 32'hffff_ffff, high_status)
		wait_pin(1'b0, 3, "all pin");
		@(negedge clk);
		`CHK("monitor latch", 1'b1, safe_state)
		clr_all();
		wait_pin(1'b1, 40, "all release");
		$display("test all channels done");
	endtask
	task automatic t_low_irq();
		for (int p = 0; p < 3; p++) begin
			@(posedge clk);
			int_en <= (p < 2) ? 64'h1 << 20 : 64'h0;
			hi_pri <= (p == 1) ? 64'h1 << 20 : 64'h0;
			ext[2] <= 1'b1;
			@(posedge clk); ext[2] <= 1'b0;
			@(negedge clk);
			@(negedge clk);
			`CHK("low pri line", p == 0, irq_low_pri)
			`CHK("high pri line", p == 1, irq_high_pri)
			`CHK("no nmi", 1'b0, nmi_irq)
			`CHK("pin disabled", 1'b1, fault_out_n)
			clr_all();
			@(negedge clk);
			`CHK("irq drop", 2'b00, {irq_low_pri, irq_high_pri})
		end
		// Same channel routed to the pin, interrupt masked
		@(posedge clk); int_en <= '0; pin_en <= 64'h1 << 20; ext[2] <= 1'b1;
		@(posedge clk); ext[2] <= 1'b0;
		@(negedge clk);
		wait_pin(1'b0, 4, "low pin");
		`CHK("masked lines", 2'b00, {irq_low_pri, irq_high_pri})
		clr_all();
		@(posedge clk); pin_en <= '0;
		@(negedge clk);
		wait_pin(1'b1, 40, "low release");
		$display("test low group done");
	endtask
	task automatic t_mid_high();
		for (int c = 0; c < 32; c += 31) begin
			@(posedge clk); mid_in[c] <= 1'b1;
			@(posedge clk); mid_in[c] <= 1'b0;
			@(negedge clk);
			`CHK("mid status", 32'h1 << c, mid_status)
			@(negedge clk);
			`CHK("nmi", 1'b1, nmi_irq)
			wait_pin(1'b0, 2, "mid pin");
			clr_all();
			wait_pin(1'b1, 40, "mid release");
			@(posedge clk); high_in[c] <= 1'b1;
			@(posedge clk); high_in[c] <= 1'b0;
			@(negedge clk);
			`CHK("high status", 32'h1 << c, high_status)
			@(negedge clk);
			`CHK("high no irq", 3'b000, {nmi_irq, irq_low_pri, irq_high_pri})
			wait_pin(1'b0, 2, "high pin");
			clr_all();
			wait_pin(1'b1, 40, "high release");
		end
		$display("test mid and high groups done");
	endtask
	task automatic t_force();
		// Slow time base: four clocks per tick stretches the minimum hold
		@(posedge clk); div <= 8'h03; force_error <= 1'b1;
		@(posedge clk); force_error <= 1'b0;
		@(negedge clk);
		wait_pin(1'b0, 3, "forced pin");
		@(negedge clk);
		`CHK("monitor safe", 1'b1, safe_state)
		repeat (5) @(negedge clk);
		`CHK("hold on slow base", 1'b0, fault_out_n)
		wait_pin(1'b1, 30, "forced release");
		@(posedge clk); div <= 8'h00;
		$display("test forced error done");
	endtask
	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		t_named();
		t_all();
		t_low_irq();
		t_mid_high();
		t_force();
		end_sim();
	end
endmodule
`default_nettype wire
